/* File: shared/sspbs_consts.vh */
/*
 supply supervisor constants: field widths, reset values, timing counts.
 assumes a 40 MHz system clock.
*/
`ifndef SSPBS_CONSTS_VH
`define SSPBS_CONSTS_VH

`define SSPBS_CLK_MHZ 40
`define SSPBS_TEMPO_US 2000
`define SSPBS_TEMPO_CYC (`SSPBS_TEMPO_US * `SSPBS_CLK_MHZ)
`define SSPBS_LVL_W 3
`define SSPBS_LVL_RST 3'h0
`define SSPBS_EVT_LINE 16
`define SSPBS_MODE_RUN 2'h0
`define SSPBS_MODE_STOP 2'h1
`define SSPBS_MODE_STBY 2'h2
`define SSPBS_REG_FULL 2'h0
`define SSPBS_REG_LOWP 2'h1
`define SSPBS_REG_OFF 2'h2
`define SSPBS_PIN_GPIO 2'h0
`define SSPBS_PIN_OSC 2'h1
`define SSPBS_PIN_TAMP 2'h1
`define SSPBS_PIN_CAL 2'h2
`define SSPBS_PIN_ALRM 2'h3

`endif

/* File: hw/sspbs_sync.v */
/*
 two flip-flop synchroniser for an asynchronous level.
 assumes one system clock; the first stage is read only by the second.
*/
`timescale 1ns/100ps
`default_nettype none
module sspbs_sync #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst,
    input wire i_ce,
    // async level in, synced level out
    input wire i_async,
    output reg o_sync
);
    reg meta_q;

    always @(posedge i_clock) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: hw/sspbs_top.v */
/*
 supply supervisor and backup switch control: reset hold, voltage detector,
 backup supply selection, backup pin function gating, regulator mode.
 assumes analog comparators deliver asynchronous levels on pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sspbs_consts.vh"

// Operation
// - hold device reset while main or analog supply is below threshold
// - detector threshold chosen by three-bit level select field
// - detector gives no result unless its enable bit is set
// - output flag shows supply above or below selected threshold
// - detector output drives external event line sixteen
// - interrupt on falling, rising or both edges per line configuration
// - backup supply selection governed by power-down reset circuit
// - backup switch on battery during startup delay and after power-down
// - on main supply all backup pin functions allowed
// - on battery oscillator pins oscillator only, tamper pin restricted
// - regulator enabled at full power after every reset
// - regulator low power in stop only if stop low-power bit set, else full power; off in standby
// - stop entry waits for flash programming and bus access to finish
module sspbs_top #(
    parameter TEMPO_CYC = `SSPBS_TEMPO_CYC,
    parameter LVL_W = `SSPBS_LVL_W
) (
    // clock, reset, enable
    input wire i_clock,
    input wire i_rst,
    input wire i_ce,
    // supply comparators (async)
    input wire i_main_ok,
    input wire i_analog_ok,
    input wire i_det_above,
    // detector control
    input wire [LVL_W-1:0] i_detector_level_select,
    input wire i_detector_enable_bit,
    output reg [LVL_W-1:0] o_det_level,
    output wire o_det_enable,
    output reg o_detector_output_flag,
    // external event line controller
    input wire i_evt_rise_en,
    input wire i_evt_fall_en,
    output reg o_evt_line,
    output reg o_evt_irq,
    // reset and backup switch
    output wire o_sys_reset,
    output reg o_backup_on_battery,
    // backup pin function requests and grants
    input wire [1:0] i_tamper_pin_func,
    input wire [1:0] i_osc_pin_func,
    output reg [1:0] o_backup_tamper_pin_func,
    output reg [1:0] o_backup_osc_in_pin_func,
    output reg [1:0] o_backup_osc_out_pin_func,
    // low power mode control
    input wire [1:0] i_mode_req,
    input wire i_stop_lowpower,
    input wire i_flash_busy,
    input wire i_bus_busy,
    output reg [1:0] o_mode,
    output reg [1:0] o_regulator_mode
);
    localparam ST_ON = 2'h0;
    localparam ST_TEMPO = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam CW = 32;

    wire main_s;
    wire ana_s;
    wire det_s;
    reg [1:0] st_q;
    reg [CW-1:0] cnt_q;
    reg det_prev_q;
    wire supply_ok;

    function [1:0] gate_tamper;
        input on_bat;
        input [1:0] req;
        begin
            if (on_bat && (req == `SSPBS_PIN_GPIO || req == `SSPBS_PIN_CAL))
                gate_tamper = `SSPBS_PIN_TAMP;
            else
                gate_tamper = req;
        end
    endfunction

    sspbs_sync #(.RST_VAL(1'b0)) u_main (
        .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
        .i_async(i_main_ok), .o_sync(main_s)
    );
    sspbs_sync #(.RST_VAL(1'b0)) u_ana (
        .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
        .i_async(i_analog_ok), .o_sync(ana_s)
    );
    sspbs_sync #(.RST_VAL(1'b0)) u_det (
        .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
        .i_async(i_det_above), .o_sync(det_s)
    );

    assign supply_ok = main_s & ana_s;

    // reset until supplies good and tempo done
    assign o_sys_reset = (st_q != ST_RUN);

    always @(posedge i_clock) begin
        if (i_rst) begin
            st_q <= ST_ON;
            cnt_q <= {CW{1'b0}};
            o_backup_on_battery <= 1'b1;
        end else if (i_ce) begin
            case (st_q)
                ST_ON: begin
                    o_backup_on_battery <= 1'b1;
                    cnt_q <= {CW{1'b0}};
                    if (supply_ok)
                        st_q <= ST_TEMPO;
                end
                ST_TEMPO: begin
                    o_backup_on_battery <= 1'b1;
                    if (!supply_ok) begin
                        st_q <= ST_ON;
                    end else if (cnt_q >= TEMPO_CYC - 1) begin
                        st_q <= ST_RUN;
                        o_backup_on_battery <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!supply_ok) begin
                        st_q <= ST_ON;
                        o_backup_on_battery <= 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_ON;
                    o_backup_on_battery <= 1'b1;
                end
            endcase
        end
    end

    assign o_det_enable = i_detector_enable_bit;

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_det_level <= `SSPBS_LVL_RST;
            o_detector_output_flag <= 1'b0;
            o_evt_line <= 1'b0;
            o_evt_irq <= 1'b0;
            det_prev_q <= 1'b0;
        end else if (i_ce) begin
            o_det_level <= i_detector_level_select;
            // flag high when supply below threshold
            o_detector_output_flag <= i_detector_enable_bit & ~det_s;
            o_evt_line <= i_detector_enable_bit & ~det_s;
            det_prev_q <= o_evt_line;
            o_evt_irq <= (i_evt_rise_en & o_evt_line & ~det_prev_q) |
                (i_evt_fall_en & ~o_evt_line & det_prev_q);
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_backup_tamper_pin_func <= `SSPBS_PIN_TAMP;
            o_backup_osc_in_pin_func <= `SSPBS_PIN_OSC;
            o_backup_osc_out_pin_func <= `SSPBS_PIN_OSC;
        end else if (i_ce) begin
            o_backup_tamper_pin_func <= gate_tamper(o_backup_on_battery, i_tamper_pin_func);
            if (o_backup_on_battery) begin
                o_backup_osc_in_pin_func <= `SSPBS_PIN_OSC;
                o_backup_osc_out_pin_func <= `SSPBS_PIN_OSC;
            end else begin
                o_backup_osc_in_pin_func <= i_osc_pin_func;
                o_backup_osc_out_pin_func <= i_osc_pin_func;
            end
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_mode <= `SSPBS_MODE_RUN;
            o_regulator_mode <= `SSPBS_REG_FULL;
        end else if (i_ce) begin
            case (i_mode_req)
                `SSPBS_MODE_STOP: begin
                    // wait for flash and bus idle
                    if (o_mode == `SSPBS_MODE_STOP || (!i_flash_busy && !i_bus_busy)) begin
                        o_mode <= `SSPBS_MODE_STOP;
                        o_regulator_mode <= i_stop_lowpower ? `SSPBS_REG_LOWP :
                            `SSPBS_REG_FULL;
                    end
                end
                `SSPBS_MODE_STBY: begin
                    o_mode <= `SSPBS_MODE_STBY;
                    o_regulator_mode <= `SSPBS_REG_OFF;
                end
                default: begin
                    o_mode <= `SSPBS_MODE_RUN;
                    o_regulator_mode <= `SSPBS_REG_FULL;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: tb/sspbs_rails.sv */
/* rails and event controller model. assumes levels commanded by the bench. */
`timescale 1ns/100ps
`default_nettype none
module sspbs_rails (
    input wire logic i_clock,
    input wire logic i_vdd_on,
    input wire logic i_vdd_low,
    input wire logic i_irq,
    output wire logic o_main_ok,
    output wire logic o_analog_ok,
    output wire logic o_det_above,
    output int o_irq_cnt
);
    // comparators settle a little after the clock edge
    assign #3 o_main_ok = i_vdd_on;
    assign #4 o_analog_ok = i_vdd_on;
    assign #5 o_det_above = i_vdd_on && !i_vdd_low;
    initial o_irq_cnt = 0;
    always @(posedge i_clock) o_irq_cnt <= o_irq_cnt + int'(i_irq === 1'b1);
endmodule
`default_nettype wire

/* File: tb/sspbs_asserts.sv */
/* checker on the top ports. assumes the clock enable stays high. */
`timescale 1ns/100ps
`default_nettype none
`include "sspbs_consts.vh"
module sspbs_asserts #(parameter TEMPO_CYC = 8) (
    input wire logic i_clock, i_rst, i_main_ok, i_analog_ok, i_det_above,
    input wire logic i_detector_enable_bit, i_evt_rise_en, i_evt_fall_en,
    input wire logic i_flash_busy, i_bus_busy, o_detector_output_flag,
    input wire logic o_evt_line, o_evt_irq, o_sys_reset, o_backup_on_battery,
    input wire logic [1:0] o_backup_tamper_pin_func, o_backup_osc_in_pin_func,
    input wire logic [1:0] o_mode, o_regulator_mode
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence det_low; (i_detector_enable_bit && !i_det_above) [*4]; endsequence
    sequence det_off; !i_detector_enable_bit [*2]; endsequence
    reset_hold_a: assert property (!(i_main_ok && i_analog_ok) |-> ##[1:3] o_sys_reset)
        else $error("reset not held");
    bat_reset_a: assert property (o_sys_reset |-> o_backup_on_battery)
        else $error("not on battery");
    tempo_a: assert property ($fell(o_sys_reset) |-> !o_backup_on_battery
        && $past(i_main_ok && i_analog_ok, TEMPO_CYC + 1)) else $error("early release");
    flag_low_a: assert property (det_low |-> o_detector_output_flag)
        else $error("flag not set");
    det_off_a: assert property (det_off |-> !o_detector_output_flag)
        else $error("flag while off");
    line_eq_a: assert property (o_evt_line == o_detector_output_flag)
        else $error("line differs");
    irq_edge_a: assert property (($rose(o_evt_line) && i_evt_rise_en)
        || ($fell(o_evt_line) && i_evt_fall_en) |-> ##1 o_evt_irq ##1 !o_evt_irq)
        else $error("edge irq wrong");
    stop_gate_a: assert property ($rose(o_mode == `SSPBS_MODE_STOP)
        |-> $past(!i_flash_busy && !i_bus_busy)) else $error("stop while busy");
    stby_off_a: assert property (o_mode == `SSPBS_MODE_STBY
        |-> o_regulator_mode == `SSPBS_REG_OFF) else $error("regulator on");
    pin_bat_a: assert property ($past(o_backup_on_battery) |->
        o_backup_osc_in_pin_func == `SSPBS_PIN_OSC && o_backup_tamper_pin_func[0])
        else $error("pin grant");
endmodule
bind sspbs_top sspbs_asserts #(.TEMPO_CYC(TEMPO_CYC)) u_chk (.*);
`default_nettype wire

/* File: tb/sspbs_top_tb.sv */
/* bench for the supervisor. assumes the rails model drives the comparators. */
`timescale 1ns/100ps
`default_nettype none
`include "sspbs_consts.vh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); end end
module sspbs_top_tb;
    localparam int TEMPO = 8;
    logic clock = 1'b0, rst = 1'b1, vdd = 1'b0, low = 1'b0, en = 1'b0, re = 1'b0, fe = 1'b0;
    logic lp = 1'b0, fb = 1'b0, bb = 1'b0, ce = 1'b1;
    logic [2:0] lvl = 3'h0;
    logic [1:0] tq = 2'h0, oq = 2'h0, mq = 2'h0;
    wire mok, aok, above, fl, ln, irq, sr, bat, de;
    wire [2:0] dl;
    wire [1:0] tg, og, oo, md, rm;
    int cnt, num_errors = 0, n_tests = 0, base;
    always #12.5 clock = ~clock;
    sspbs_rails i_rails (.i_clock(clock), .i_vdd_on(vdd), .i_vdd_low(low), .i_irq(irq),
        .o_main_ok(mok), .o_analog_ok(aok), .o_det_above(above), .o_irq_cnt(cnt));
    sspbs_top #(.TEMPO_CYC(TEMPO)) i_dut (.i_clock(clock), .i_rst(rst), .i_ce(ce),
        .i_main_ok(mok), .i_analog_ok(aok), .i_det_above(above), .i_detector_level_select(lvl),
        .i_detector_enable_bit(en), .o_det_level(dl), .o_det_enable(de),
        .o_detector_output_flag(fl), .i_evt_rise_en(re), .i_evt_fall_en(fe), .o_evt_line(ln),
        .o_evt_irq(irq), .o_sys_reset(sr), .o_backup_on_battery(bat), .i_tamper_pin_func(tq),
        .i_osc_pin_func(oq), .o_backup_tamper_pin_func(tg), .o_backup_osc_in_pin_func(og),
        .o_backup_osc_out_pin_func(oo), .i_mode_req(mq), .i_stop_lowpower(lp),
        .i_flash_busy(fb), .i_bus_busy(bb), .o_mode(md), .o_regulator_mode(rm));
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic power_up;
        int k;
        k = 0;
        vdd = 1'b1;
        while (sr !== 1'b0 && k < 100) begin
            cyc(1);
            k++;
        end
        // two sync flops, one state edge, then the startup delay
        `CHK("startup wait", TEMPO + 3, k)
        `CHK("reset released", 1'b0, sr)
        `CHK("battery", 1'b0, bat)
        $display("power up done");
    endtask
    task automatic t_drop;
        vdd = 1'b0;
        tq = `SSPBS_PIN_CAL;
        cyc(5);
        `CHK("reset", 1'b1, sr)
        `CHK("tamper grant", `SSPBS_PIN_TAMP, tg)
        `CHK("osc grant", `SSPBS_PIN_OSC, og)
        `CHK("osc out grant", `SSPBS_PIN_OSC, oo)
        power_up();
        cyc(1);
        `CHK("tamper grant", `SSPBS_PIN_CAL, tg)
        `CHK("osc grant", `SSPBS_PIN_GPIO, og)
        `CHK("osc out grant", `SSPBS_PIN_GPIO, oo)
    endtask
    task automatic t_det;
        for (int i = 0; i < 8; i++) begin
            lvl = i[2:0];
            cyc(2);
            `CHK("level", i[2:0], dl)
        end
        `CHK("enable off", 1'b0, de)
        en = 1'b1;
        re = 1'b1;
        fe = 1'b1;
        base = cnt;
        cyc(1);
        `CHK("enable on", 1'b1, de)
        low = 1'b1;
        cyc(5);
        `CHK("flag", 1'b1, fl)
        low = 1'b0;
        cyc(5);
        fe = 1'b0;
        low = 1'b1;
        cyc(5);
        low = 1'b0;
        cyc(5);
        `CHK("edges", base + 3, cnt)
        en = 1'b0;
        low = 1'b1;
        cyc(5);
        `CHK("flag off", 1'b0, fl)
        $display("detector done");
    endtask
    task automatic t_mode;
        fb = 1'b1;
        bb = 1'b1;
        lp = 1'b1;
        mq = `SSPBS_MODE_STOP;
        cyc(4);
        fb = 1'b0;
        cyc(4);
        `CHK("mode", `SSPBS_MODE_RUN, md)
        bb = 1'b0;
        cyc(2);
        `CHK("regulator", `SSPBS_REG_LOWP, rm)
        mq = `SSPBS_MODE_STBY;
        cyc(2);
        `CHK("regulator", `SSPBS_REG_OFF, rm)
        mq = `SSPBS_MODE_RUN;
        cyc(2);
        `CHK("regulator", `SSPBS_REG_FULL, rm)
        // clock enable low must freeze the mode state
        ce = 1'b0;
        mq = `SSPBS_MODE_STBY;
        cyc(2);
        `CHK("frozen regulator", `SSPBS_REG_FULL, rm)
        ce = 1'b1;
        cyc(2);
        `CHK("regulator", `SSPBS_REG_OFF, rm)
        $display("modes done");
    endtask
    initial begin
        cyc(16);
        `CHK("battery in reset", 1'b1, bat)
        rst = 1'b0;
        power_up();
        t_drop();
        t_det();
        t_mode();
        end_of_test();
    end
    initial begin
        #(25 * 3000);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
